/* File: usm_master_spi.sv */
// master serial peripheral mode of a synchronous/asynchronous transceiver
// assumes a classic wishbone master and an external slave on the pins
// Operation
// (RQ1) master mode only when mode select is 11
// (RQ2) transfer clock always generated internally
// (RQ3) software sets clock pin direction as output
// (RQ4) bit rate is clock over 2*(divisor+1)
// (RQ5) four polarity/phase modes pick sample edges
// (RQ6) drive and sample on opposite clock edges
// (RQ7) mode changes mid-frame corrupt the transfer
// (RQ8) frames are exactly eight data bits
// (RQ9) one bit-order bit, lsb-first when set
// (RQ10) next frame follows at once, else idle high
// (RQ11) two queued bytes give one 16-bit burst
// (RQ12) software keeps divisor zero while enabling transmitter
// (RQ13) baud divisor resets to zero
// (RQ14) software checks flags before changing settings
// (RQ15) transmitter enable takes over the output pin
// (RQ16) optional receiver enable takes over input pin
// (RQ17) receiver depends on transmitter-driven clock
// (RQ18) only data writes start transfers; a byte buffered while mode select is not 11 starts when a frame write sets 11
// (RQ19) buffered byte enters shifter when it frees
// (RQ20) software reads one byte per byte sent
// (RQ21) on overflow newest received byte is dropped
// (RQ22) framing, overrun and parity flags read zero
// (RQ23) transmit complete sets when drained, one clears
// (RQ24) clock idles at the polarity level
module usm_master_spi (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // classic wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // pins
  input  wire logic        transfer_clock_dir_bit_i,
  output logic             transfer_clock_pin_o,
  output logic             transfer_clock_pin_oe_o,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe_o,
  input  wire logic        serial_in_pin_i,
  output logic             serial_in_override_o
);
  import usm_pkg::*;

  typedef struct packed {
    logic                              ack;
    logic [31:0]                       dat;
    logic                              txen;
    logic                              rxen;
    logic [1:0]                        mode;
    logic                              dord;
    logic                              cpha;
    logic                              cpol;
    logic [USM_DIV_W-1:0]              baud;
    logic [7:0]                        txbuf;
    logic                              txfull;
    logic                              txc;
    usm_state_t                        state;
    logic [3:0]                        edge_cnt;
    logic                              phase;
    logic [7:0]                        tx_sh;
    logic [7:0]                        rx_sh;
    logic                              out;
    logic [USM_RX_DEPTH-1:0][7:0]      rx_mem;
    logic [1:0]                        rx_cnt;
  } usm_regs_t;

  usm_regs_t r_reg;
  usm_regs_t r_next;
  logic      tick;
  logic      run;

  // bit that leaves the shifter first for the chosen order
  function automatic logic first_bit(input logic [7:0] d, input logic lsb_first);
    first_bit = lsb_first ? d[0] : d[7];
  endfunction

  // shifter after its outgoing bit has left
  function automatic logic [7:0] shift_out(input logic [7:0] d, input logic lsb_first);
    shift_out = lsb_first ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
  endfunction

  // receive shifter with one sampled bit added
  function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b, input logic lsb_first);
    shift_in = lsb_first ? {b, d[7:1]} : {d[6:0], b};
  endfunction

  // half-bit ticks only while a frame is on the wire
  assign run = (r_reg.state == USM_ST_SHIFT);

  usm_baud_gen i_usm_baud_gen (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (run),
    .div_i  (r_reg.baud),
    .tick_o (tick)
  );

  // next-state logic: bus slave, transmit buffer, shifter, receive buffer
  always_comb begin
    logic       acc;
    logic       wr;
    logic       rd;
    logic       sample_edge;
    logic       last;
    logic       frame_done;
    logic       load;
    logic [1:0] cnt;
    logic [7:0] rx_byte;
    acc         = 1'b0;
    wr          = 1'b0;
    rd          = 1'b0;
    sample_edge = 1'b0;
    last        = 1'b0;
    frame_done  = 1'b0;
    load        = 1'b0;
    cnt         = 2'h0;
    rx_byte     = 8'h00;
    r_next      = r_reg;

    // one-cycle ack, dropped in the cycle after it was given
    acc        = cyc_i && stb_i && !r_reg.ack;
    wr         = acc && we_i && sel_i[0];
    rd         = acc && !we_i;
    r_next.ack = acc;

    // read data mux, reserved and error bits read zero
    if (rd) begin
      r_next.dat = 32'h0000_0000;
      case (adr_i)
        USM_DATA_OFS: begin
          r_next.dat[7:0] = r_reg.rx_mem[0];
        end
        USM_STATUS_OFS: begin
          r_next.dat[USM_RXC_BIT]  = (r_reg.rx_cnt != 2'h0);
          r_next.dat[USM_TXC_BIT]  = r_reg.txc;
          r_next.dat[USM_UDRE_BIT] = !r_reg.txfull; // RQ22
        end
        USM_ENABLE_OFS: begin
          r_next.dat[USM_RXEN_BIT] = r_reg.rxen;
          r_next.dat[USM_TXEN_BIT] = r_reg.txen;
        end
        USM_FRAME_OFS: begin
          r_next.dat[USM_MODE_HI:USM_MODE_LO] = r_reg.mode;
          r_next.dat[USM_DORD_BIT]            = r_reg.dord;
          r_next.dat[USM_CPHA_BIT]            = r_reg.cpha;
          r_next.dat[USM_CPOL_BIT]            = r_reg.cpol;
        end
        USM_BAUD_OFS: begin
          r_next.dat[USM_DIV_W-1:0] = r_reg.baud;
        end
        default: begin
          r_next.dat = 32'h0000_0000;
        end
      endcase
    end

    // register writes; live changes are not guarded
    if (wr) begin
      case (adr_i)
        USM_DATA_OFS: begin
          if (!r_reg.txfull && r_reg.txen) begin
            r_next.txbuf  = dat_i[7:0]; // RQ18
            r_next.txfull = 1'b1;
          end
        end
        USM_STATUS_OFS: begin
          if (dat_i[USM_TXC_BIT]) begin
            r_next.txc = 1'b0; // RQ23
          end
        end
        USM_ENABLE_OFS: begin
          r_next.rxen = dat_i[USM_RXEN_BIT];
          r_next.txen = dat_i[USM_TXEN_BIT];
        end
        USM_FRAME_OFS: begin
          r_next.mode = dat_i[USM_MODE_HI:USM_MODE_LO];
          r_next.dord = dat_i[USM_DORD_BIT]; // RQ7
          r_next.cpha = dat_i[USM_CPHA_BIT];
          r_next.cpol = dat_i[USM_CPOL_BIT];
        end
        USM_BAUD_OFS: begin
          r_next.baud = dat_i[USM_DIV_W-1:0];
        end
        default: begin
          r_next.ack = acc;
        end
      endcase
    end

    // receive buffer pop on a data read
    cnt = r_reg.rx_cnt;
    if (rd && (adr_i == USM_DATA_OFS) && (cnt != 2'h0)) begin
      r_next.rx_mem[0] = r_reg.rx_mem[1];
      cnt              = cnt - 2'h1;
    end

    // shift engine, sample edge picked by phase
    sample_edge = (r_reg.edge_cnt[0] == r_reg.cpha); // RQ5
    last        = (r_reg.edge_cnt == USM_LAST_EDGE); // RQ8
    case (r_reg.state)
      USM_ST_IDLE: begin
        r_next.out   = 1'b1;
        r_next.phase = 1'b0; // RQ24
        load = r_reg.txfull && (r_reg.mode == USM_MODE_MSPI); // RQ1
      end
      USM_ST_SHIFT: begin
        if (tick) begin
          r_next.phase    = !r_reg.phase; // RQ2
          r_next.edge_cnt = r_reg.edge_cnt + 4'h1;
          if (sample_edge) begin
            r_next.rx_sh = shift_in(r_reg.rx_sh, serial_in_pin_i, r_reg.dord); // RQ6
          end else if (!(last && !r_reg.cpha)) begin
            r_next.out   = first_bit(r_reg.tx_sh, r_reg.dord); // RQ9
            r_next.tx_sh = shift_out(r_reg.tx_sh, r_reg.dord);
          end
          if (last) begin
            frame_done = 1'b1;
            rx_byte    = r_reg.cpha ? shift_in(r_reg.rx_sh, serial_in_pin_i, r_reg.dord) : r_reg.rx_sh;
            load       = r_reg.txfull; // RQ10
            if (!r_reg.txfull) begin
              r_next.state = USM_ST_IDLE;
              r_next.out   = r_reg.cpha ? r_reg.out : 1'b1; // RQ6 keep last bit past its sample edge
              r_next.txc   = 1'b1; // RQ23
            end
          end
        end
      end
      default: begin
        r_next.state = USM_ST_IDLE;
      end
    endcase

    // move the buffered byte into the free shifter
    if (load) begin
      r_next.state    = USM_ST_SHIFT; // RQ19
      r_next.txfull   = 1'b0; // a data write in this cycle is refused, buffer was full
      r_next.edge_cnt = 4'h0;
      r_next.phase    = 1'b0;
      if (r_reg.cpha) begin
        r_next.tx_sh = r_reg.txbuf;
      end else begin
        r_next.out   = first_bit(r_reg.txbuf, r_reg.dord);
        r_next.tx_sh = shift_out(r_reg.txbuf, r_reg.dord);
      end
    end

    // receive buffer push, newest byte dropped when full
    if (frame_done && r_reg.rxen && r_reg.txen) begin // RQ17
      if (cnt < 2'h2) begin
        r_next.rx_mem[cnt[0]] = rx_byte; // RQ21
        cnt                   = cnt + 2'h1;
      end
    end
    r_next.rx_cnt = cnt;

    // disabling the receiver flushes its buffer
    if (!r_reg.rxen) begin
      r_next.rx_cnt = 2'h0; // RQ16
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg          <= '0;
      r_reg.state    <= USM_ST_IDLE;
      r_reg.baud     <= USM_BAUD_RST; // RQ13
      r_reg.mode     <= USM_MODE_RST;
      r_reg.dord     <= USM_DORD_RST;
      r_reg.cpha     <= USM_CPHA_RST;
      r_reg.cpol     <= USM_CPOL_RST;
      r_reg.out      <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // bus answers
  assign dat_o = r_reg.dat;
  assign ack_o = r_reg.ack;

  // pins; transmitter stays in charge until queued data has left
  assign transfer_clock_pin_o    = r_reg.phase ^ r_reg.cpol; // RQ24
  assign transfer_clock_pin_oe_o = transfer_clock_dir_bit_i;
  assign serial_out_pin_o        = r_reg.out;
  assign serial_out_pin_oe_o     = r_reg.txen || r_reg.txfull || run || !r_reg.out; // RQ15
  assign serial_in_override_o    = r_reg.rxen; // RQ16
endmodule

/* File: usm_pkg.sv */
// constants shared by the master serial peripheral mode transceiver
// assumes a 32-bit classic wishbone slave port with byte addresses
package usm_pkg;
  // register byte offsets
  localparam logic [7:0] USM_DATA_OFS   = 8'h00;
  localparam logic [7:0] USM_STATUS_OFS = 8'h04;
  localparam logic [7:0] USM_ENABLE_OFS = 8'h08;
  localparam logic [7:0] USM_FRAME_OFS  = 8'h0c;
  localparam logic [7:0] USM_BAUD_OFS   = 8'h10;
  // status field positions
  localparam int USM_RXC_BIT  = 7;
  localparam int USM_TXC_BIT  = 6;
  localparam int USM_UDRE_BIT = 5;
  // enable field positions
  localparam int USM_RXEN_BIT = 4;
  localparam int USM_TXEN_BIT = 3;
  // frame field positions
  localparam int USM_MODE_HI  = 7;
  localparam int USM_MODE_LO  = 6;
  localparam int USM_DORD_BIT = 2;
  localparam int USM_CPHA_BIT = 1;
  localparam int USM_CPOL_BIT = 0;
  // mode select value for master serial peripheral mode
  localparam logic [1:0] USM_MODE_MSPI = 2'h3;
  // widths and counts
  localparam int         USM_DIV_W      = 12;
  localparam logic [3:0] USM_LAST_EDGE  = 4'hf;
  localparam int         USM_RX_DEPTH   = 2;
  // reset values
  localparam logic [11:0] USM_BAUD_RST  = 12'h000;
  localparam logic [1:0]  USM_MODE_RST  = 2'h0;
  localparam logic        USM_DORD_RST  = 1'b1;
  localparam logic        USM_CPHA_RST  = 1'b1;
  localparam logic        USM_CPOL_RST  = 1'b0;

  typedef enum logic [1:0] {
    USM_ST_IDLE  = 2'b01,
    USM_ST_SHIFT = 2'b10
  } usm_state_t;
endpackage

/* File: usm_baud_gen.sv */
// half-bit tick generator for the transfer clock
// assumes run is held high for the whole of a frame sequence
module usm_baud_gen (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         run_i,
  input  wire logic [usm_pkg::USM_DIV_W-1:0] div_i,
  output logic                              tick_o
);
  import usm_pkg::*;

  typedef struct packed {
    logic [USM_DIV_W-1:0] cnt;
  } usm_bg_state_t;

  usm_bg_state_t st_reg;
  usm_bg_state_t st_next;

  // tick every div+1 cycles, so one bit lasts 2*(div+1) cycles
  assign tick_o = run_i && (st_reg.cnt == div_i); // RQ4

  // count while running, restart from zero when stopped
  always_comb begin
    st_next = st_reg;
    if (!run_i || tick_o) begin
      st_next.cnt = '0;
    end else begin
      st_next.cnt = st_reg.cnt + 12'h001;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

/* File: usm_master_spi_properties.sv */
// port checker for the master serial peripheral mode transceiver
// assumes one clock domain; bound to the top module below
module usm_master_spi_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        transfer_clock_dir_bit_i,
  input wire logic        transfer_clock_pin_o,
  input wire logic        transfer_clock_pin_oe_o,
  input wire logic        serial_out_pin_o,
  input wire logic        serial_out_pin_oe_o,
  input wire logic        serial_in_pin_i,
  input wire logic        serial_in_override_o
);
  import usm_pkg::*;
  // every check runs on the system clock, off during reset
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in the next cycle");
  a_ack_has_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  a_clk_dir_pass: assert property (transfer_clock_pin_oe_o == transfer_clock_dir_bit_i)
    else $error("clock pin enable ignores direction bit");
  a_line_idle_high: assert property (!serial_out_pin_oe_o |-> serial_out_pin_o)
    else $error("serial output low while released");
  a_flags_read_zero: assert property (ack_o && !we_i && adr_i == USM_STATUS_OFS |-> dat_o[4:0] == 5'h00)
    else $error("error flags not zero");
  a_clk_still_idle: assert property ($changed(transfer_clock_pin_o) && !serial_out_pin_oe_o
    |-> ack_o || $past(ack_o) || $past(serial_out_pin_oe_o))
    else $error("clock moved with no transfer");
  a_pins_after_reset: assert property ($fell(rst_i) |-> !serial_out_pin_oe_o && !serial_in_override_o)
    else $error("pins taken over after reset");
  c_data_write: cover property (ack_o && we_i && adr_i == USM_DATA_OFS);
  c_clock_toggle: cover property (serial_out_pin_oe_o && $changed(transfer_clock_pin_o));
  c_status_read: cover property (ack_o && !we_i && adr_i == USM_STATUS_OFS);
endmodule
bind usm_master_spi usm_master_spi_properties i_usm_master_spi_properties (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .transfer_clock_dir_bit_i, .transfer_clock_pin_o,
  .transfer_clock_pin_oe_o, .serial_out_pin_o, .serial_out_pin_oe_o, .serial_in_pin_i, .serial_in_override_o);

/* File: usm_spi_slave.sv */
// behavioural external slave on the transfer clock and data lines
// assumes hold_i is high while the master is configured
module usm_spi_slave (
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       hold_i,
  input  wire logic [7:0] reply_i,
  output logic            miso_o,
  output logic [15:0]     got_o
);
  logic [7:0] sh;
  logic [7:0] nxt;
  logic       seen;
  int         n;
  // preload the first reply while held; then sample on one clock edge
  // and shift out on the other, later replies counting up
  always @(hold_i or reply_i or cpha_i or sclk_i) begin
    if (hold_i) begin
      sh = reply_i;
      nxt = reply_i + {7'h00, !cpha_i};
      n = 0;
      got_o = 16'h0000;
      seen = sclk_i;
    end else if (sclk_i !== seen) begin
      seen = sclk_i;
      if (sclk_i == !(cpol_i ^ cpha_i)) begin
        got_o = {got_o[14:0], mosi_i};
        n = (n + 1) % 8;
      end else if (n == 0) begin
        sh = nxt;
        nxt = nxt + 8'h01;
      end else begin
        sh = {sh[6:0], 1'b0};
      end
    end
  end
  assign miso_o = sh[7];
endmodule

/* File: test_usm_master_spi.sv */
// self-checking bench for the master serial peripheral mode transceiver
// assumes the slave model and the checker are compiled first
module test_usm_master_spi;
  timeunit 1ns;
  timeprecision 1ps;
  import usm_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic        dir = 1'b0;
  logic        cpol = 1'b0;
  logic        cpha = 1'b0;
  logic        hold = 1'b1;
  logic [7:0]  reply = 8'h00;
  logic [31:0] dat_o, q;
  logic [15:0] got;
  logic        ack_o, sck, sck_oe, sout, sout_oe, sin, ovr, last_sck;
  int          fail_count = 0;
  int          tests_run = 0;
  int          tog, span, cnt, t0;
  always #2 clk_i = ~clk_i;
  usm_master_spi i_usm_master_spi (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .transfer_clock_dir_bit_i(dir), .transfer_clock_pin_o(sck), .transfer_clock_pin_oe_o(sck_oe),
    .serial_out_pin_o(sout), .serial_out_pin_oe_o(sout_oe), .serial_in_pin_i(sin), .serial_in_override_o(ovr));
  usm_spi_slave i_usm_spi_slave (.sclk_i(sck), .mosi_i(sout), .cpol_i(cpol), .cpha_i(cpha), .hold_i(hold),
    .reply_i(reply), .miso_o(sin), .got_o(got));
  // count clock toggles and the cycles from the first to the last
  always @(posedge clk_i) begin
    cnt++;
    if (sck !== last_sck) begin
      if (tog == 0) t0 = cnt;
      span = cnt - t0;
      tog++;
    end
    last_sck = sck;
  end
  // one classic bus cycle; waits for ack, then releases for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    q = dat_o;
    if (n >= 20) begin
      fail_count++;
      $display("mismatch at %0t: no bus answer", $time);
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // poll status until the transmitter has drained
  task automatic drain();
    int n;
    n = 0;
    do begin
      wb(1'b0, USM_STATUS_OFS, 32'h0);
      n++;
    end while (q[USM_TXC_BIT] !== 1'b1 && n < 300);
    if (q[USM_TXC_BIT] !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: transmitter never drained", $time);
    end
  endtask
  function automatic logic [7:0] wire_ord(input logic [7:0] b, input logic lsb);
    for (int i = 0; i < 8; i++) wire_ord[i] = lsb ? b[7-i] : b[i];
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bound the run well above the expected length
  initial begin
    #200000;
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
  // reset values, receiver alone, all clock modes, then a queued burst
  initial begin
    logic [7:0]  d;
    logic [11:0] div;
    logic        lsb;
    void'($urandom(32'h78e5196f));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, USM_BAUD_OFS, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, USM_STATUS_OFS, 32'h0);
    chk(q, 32'h20);
    wb(1'b0, USM_FRAME_OFS, 32'h0);
    chk(q, 32'h06);
    wb(1'b0, 8'h3c, 32'h0);
    chk(q, 32'h0);
    dir <= 1'b1;
    wb(1'b1, USM_FRAME_OFS, 32'hc0);
    chk(32'(sck_oe), 32'h1);
    wb(1'b1, USM_ENABLE_OFS, 32'h10);
    tog = 0;
    wb(1'b1, USM_DATA_OFS, 32'h5a);
    repeat (40) @(posedge clk_i);
    chk(tog, 0);
    chk(32'(sout_oe), 32'h0);
    chk(32'(ovr), 32'h1);
    wb(1'b1, USM_ENABLE_OFS, 32'h18);
    chk(32'(sout_oe), 32'h1);
    for (int m = 0; m < 8; m++) begin
      hold <= 1'b1;
      cpol <= m[0];
      cpha <= m[1];
      lsb = m[2];
      div = 12'($urandom_range(3));
      d = 8'($urandom);
      reply <= 8'($urandom);
      wb(1'b1, USM_FRAME_OFS, {24'h0, 5'h18, m[2:0]});
      wb(1'b1, USM_BAUD_OFS, {20'h0, div});
      wb(1'b1, USM_STATUS_OFS, 32'h40);
      hold <= 1'b0;
      tog = 0;
      wb(1'b1, USM_DATA_OFS, {24'h0, d});
      drain();
      chk(32'(got[7:0]), 32'(wire_ord(d, lsb)));
      chk(tog, 16);
      chk(span, 15 * (div + 1));
      chk(32'(sout), 32'h1);
      chk(32'(sck), 32'(m[0]));
      wb(1'b0, USM_DATA_OFS, 32'h0);
      chk(q, {24'h0, wire_ord(reply, lsb)});
    end
    hold <= 1'b1;
    reply <= 8'($urandom);
    wb(1'b1, USM_STATUS_OFS, 32'h40);
    hold <= 1'b0;
    tog = 0;
    for (int k = 0; k < 3; k++) begin
      do wb(1'b0, USM_STATUS_OFS, 32'h0); while (q[USM_UDRE_BIT] !== 1'b1);
      if (k == 2) chk(32'(q[USM_TXC_BIT]), 32'h0);
      wb(1'b1, USM_DATA_OFS, {24'h0, d + 8'(k)});
    end
    drain();
    chk(tog, 48);
    chk(span, 47 * (div + 1));
    chk(32'(got), {16'h0, wire_ord(d + 8'h01, lsb), wire_ord(d + 8'h02, lsb)});
    wb(1'b0, USM_DATA_OFS, 32'h0);
    chk(q, {24'h0, wire_ord(reply, lsb)});
    wb(1'b0, USM_DATA_OFS, 32'h0);
    chk(q, {24'h0, wire_ord(reply + 8'h01, lsb)});
    wb(1'b1, USM_STATUS_OFS, 32'h40);
    wb(1'b0, USM_STATUS_OFS, 32'h0);
    chk(q, 32'h20);
    wrap_up();
  end
endmodule
